// >>> src/anr_regs.sv
// Purpose: advertisement and partner ability registers with mode control
// Assumes: management port is a simple synchronous read/write strobe pair
// Notes: read data registered, one cycle after rd strobe
`timescale 1ns/10ps
`default_nettype none
module anr_regs
  import anr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hardware_software_select_pin,
  input wire anr_mgmt_req_s mgmt_req,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic partner_word_valid,
  input wire logic [15:0] partner_word,
  input wire logic neg_complete,
  input wire logic local_fault,
  output logic [15:0] tx_code_word,
  output logic tx_code_valid,
  output anr_mode_s mode
);
  // ==========================================================
  // register state
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] adv_r;
  logic [15:0] adv_nxt;
  logic [15:0] ext_r;
  logic [15:0] ext_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic done_r;
  logic done_nxt;
  anr_state_e state_r;
  anr_state_e state_nxt;
  logic [15:0] lpa;
  logic adv_wr;
  logic ovr_ok;
  logic restart;
  logic lpa_clear;

  assign adv_wr = mgmt_req.wr && (mgmt_req.addr == ANR_ADV_ADDR);
  assign ovr_ok = hardware_software_select_pin && ext_r[ANR_EXT_OVR_BIT];
  assign restart = mgmt_req.wr && (mgmt_req.addr == ANR_CTRL_ADDR)
    && mgmt_req.wdata[ANR_CTRL_RESTART_BIT];
  assign lpa_clear = restart;

  // ==========================================================
  // control, extended and advertisement registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    ext_nxt = ext_r;
    adv_nxt = adv_r;
    if (mgmt_req.wr && (mgmt_req.addr == ANR_CTRL_ADDR)) begin
      // restart bit self-clears, never stored
      ctrl_nxt = mgmt_req.wdata & ~(16'h0001 << ANR_CTRL_RESTART_BIT);
    end
    if (mgmt_req.wr && (mgmt_req.addr == ANR_EXT_ADDR)) begin
      ext_nxt = mgmt_req.wdata;
    end
    if (adv_wr && hardware_software_select_pin) begin
      adv_nxt = (adv_r & ~ANR_ADV_RW_MASK) | (mgmt_req.wdata & ANR_ADV_RW_MASK);
      if (ovr_ok) begin
        // reserved defaults left to the manager
        adv_nxt = (adv_nxt & ~ANR_ADV_OVR_MASK) | (mgmt_req.wdata & ANR_ADV_OVR_MASK);
      end
    end
    // pin low: ability bits ignore all writes
    if (adv_wr && !hardware_software_select_pin) begin
      adv_nxt = adv_r;
    end
    adv_nxt[ANR_ADV_FAULT_BIT] = local_fault;
    adv_nxt[4:0] = ANR_SEL_8023;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= ANR_CTRL_RST;
      ext_r <= ANR_EXT_RST;
      adv_r <= ANR_ADV_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      ext_r <= ext_nxt;
      adv_r <= adv_nxt;
    end
  end

  // ==========================================================
  // negotiation sequencing
  always_comb begin
    state_nxt = state_r;
    done_nxt = done_r;
    unique case (state_r)
      ANR_INIT: begin
        state_nxt = ctrl_r[ANR_CTRL_ANEN_BIT] ? ANR_NEG : ANR_IDLE;
      end
      ANR_IDLE: begin
        done_nxt = 1'b0;
        if (ctrl_r[ANR_CTRL_ANEN_BIT]) begin
          state_nxt = ANR_NEG;
        end
      end
      ANR_NEG: begin
        if (!ctrl_r[ANR_CTRL_ANEN_BIT]) begin
          state_nxt = ANR_IDLE;
        end else if (neg_complete) begin
          state_nxt = ANR_DONE;
          done_nxt = 1'b1;
        end
      end
      ANR_DONE: begin
        if (!ctrl_r[ANR_CTRL_ANEN_BIT]) begin
          state_nxt = ANR_IDLE;
          done_nxt = 1'b0;
        end
      end
    endcase
    // restart reruns the exchange with current advertisement
    if (restart && ctrl_r[ANR_CTRL_ANEN_BIT]) begin
      state_nxt = ANR_NEG;
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ANR_INIT;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_r <= done_nxt;
    end
  end

  // ==========================================================
  // mode and transmitted code word
  always_comb begin
    mode.negotiating = (state_r == ANR_NEG);
    mode.send_idle = (state_r == ANR_IDLE);
    mode.speed_100 = ctrl_r[ANR_CTRL_RATE_BIT];
    mode.full_duplex = ctrl_r[ANR_CTRL_DUPLEX_BIT];
    // tech bits matter only while negotiating
    tx_code_valid = (state_r == ANR_NEG);
    tx_code_word = mode.negotiating ? adv_r : 16'h0000;
  end

  anr_lpa_capture u_lpa (
    .clk(clk),
    .rstn(rstn),
    .clear(lpa_clear),
    .word_valid(partner_word_valid && (state_r == ANR_NEG)),
    .word(partner_word),
    .lpa(lpa)
  );

  // ==========================================================
  // management read path
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = mgmt_req.rd;
    if (mgmt_req.rd) begin
      unique case (mgmt_req.addr)
        ANR_CTRL_ADDR: rdata_nxt = ctrl_r;
        ANR_STAT_ADDR: rdata_nxt = ANR_STAT_CAPS
          | ({15'h0000, done_r} << ANR_STAT_DONE_BIT);
        ANR_ADV_ADDR: rdata_nxt = adv_r & ANR_ADV_RD_MASK;
        ANR_LPA_ADDR: rdata_nxt = lpa;
        ANR_EXT_ADDR: rdata_nxt = ext_r;
        ANR_QSTAT_ADDR: rdata_nxt = {15'h0000, done_r} << ANR_QSTAT_DONE_BIT;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign mgmt_rdata = rdata_r;
  assign mgmt_rvalid = rvalid_r;

  // ==========================================================
  // checks
  sequence s_adv_write_locked;
    adv_wr && !ovr_ok;
  endsequence

  a_adv_locked: assert property (@(posedge clk) disable iff (!rstn)
    s_adv_write_locked |=> $stable(adv_r[8:5]))
    else $error("ability bits changed while locked");
  a_pin_low_ro: assert property (@(posedge clk) disable iff (!rstn)
    adv_wr && !hardware_software_select_pin |=> $stable(adv_r[12:5]))
    else $error("ability bits written in hardware mode");
  a_adv_override: assert property (@(posedge clk) disable iff (!rstn)
    adv_wr && ovr_ok |=> adv_r[8:5] == $past(mgmt_req.wdata[8:5]))
    else $error("override write not taken");
  a_selector_fixed: assert property (@(posedge clk) disable iff (!rstn)
    tx_code_valid |-> tx_code_word[4:0] == ANR_SEL_8023)
    else $error("selector not 802.3");
  a_adv_exact: assert property (@(posedge clk) disable iff (!rstn)
    tx_code_valid |-> tx_code_word[8:5] == adv_r[8:5])
    else $error("advertised tech differs");
  a_idle_when_off: assert property (@(posedge clk) disable iff (!rstn)
    !ctrl_r[ANR_CTRL_ANEN_BIT] && state_r != ANR_INIT |=> mode.send_idle)
    else $error("not idle with negotiation off");
  a_speed_duplex: assert property (@(posedge clk) disable iff (!rstn)
    mode.send_idle |-> mode.speed_100 == ctrl_r[ANR_CTRL_RATE_BIT]
      && mode.full_duplex == ctrl_r[ANR_CTRL_DUPLEX_BIT])
    else $error("forced mode mismatch");
  a_status_caps: assert property (@(posedge clk) disable iff (!rstn)
    mgmt_req.rd && mgmt_req.addr == ANR_STAT_ADDR
      |=> (mgmt_rdata & ANR_STAT_CAPS) == ANR_STAT_CAPS)
    else $error("status caps altered");
  a_restart_neg: assert property (@(posedge clk) disable iff (!rstn)
    restart && ctrl_r[ANR_CTRL_ANEN_BIT] |=> state_r == ANR_NEG ##0 tx_code_word[8:5] == adv_r[8:5])
    else $error("restart did not renegotiate");
endmodule
`default_nettype wire

// >>> src/anr_pkg.sv
// Purpose: shared constants and types for the negotiation ability registers
// Assumes: 5-bit register address, 16-bit register data
// Notes: offsets and field positions used by both design files
package anr_pkg;
  localparam logic [4:0] ANR_CTRL_ADDR = 5'h00;
  localparam logic [4:0] ANR_STAT_ADDR = 5'h01;
  localparam logic [4:0] ANR_ADV_ADDR = 5'h04;
  localparam logic [4:0] ANR_LPA_ADDR = 5'h05;
  localparam logic [4:0] ANR_EXT_ADDR = 5'h10;
  localparam logic [4:0] ANR_QSTAT_ADDR = 5'h11;
  localparam int ANR_CTRL_RATE_BIT = 13;
  localparam int ANR_CTRL_ANEN_BIT = 12;
  localparam int ANR_CTRL_RESTART_BIT = 9;
  localparam int ANR_CTRL_DUPLEX_BIT = 8;
  localparam int ANR_STAT_DONE_BIT = 5;
  localparam int ANR_EXT_OVR_BIT = 15;
  localparam int ANR_QSTAT_DONE_BIT = 4;
  localparam int ANR_ADV_FAULT_BIT = 13;
  // status capability bits: every supported technology, never altered
  localparam logic [15:0] ANR_STAT_CAPS = 16'h7809;
  localparam logic [15:0] ANR_CTRL_RST = 16'h3100;
  localparam logic [15:0] ANR_ADV_RST = 16'h01E1;
  localparam logic [15:0] ANR_LPA_RST = 16'h0000;
  localparam logic [15:0] ANR_EXT_RST = 16'h0000;
  localparam logic [4:0] ANR_SEL_8023 = 5'h01;
  localparam logic [15:0] ANR_ADV_OVR_MASK = 16'h5FE0;
  localparam logic [15:0] ANR_ADV_RW_MASK = 16'hA000;
  localparam logic [15:0] ANR_ADV_TECH_MASK = 16'h01E0;
  localparam logic [15:0] ANR_ADV_RD_MASK = 16'hA1FF;
  localparam logic [15:0] ANR_LPA_KEEP_MASK = 16'hE1E0;

  typedef enum logic [1:0] {
    ANR_INIT = 2'b00,
    ANR_IDLE = 2'b01,
    ANR_NEG = 2'b10,
    ANR_DONE = 2'b11
  } anr_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } anr_mgmt_req_s;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic negotiating;
    logic send_idle;
  } anr_mode_s;
endpackage

// >>> src/anr_lpa_capture.sv
// Purpose: capture of the partner's link code word into the partner register
// Assumes: code word valid strobe is a one-cycle pulse in clk domain
// Notes: fixed fields forced so reserved and unsupported bits read zero
`timescale 1ns/10ps
`default_nettype none
module anr_lpa_capture
  import anr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic word_valid,
  input wire logic [15:0] word,
  output logic [15:0] lpa
);
  logic [15:0] lpa_r;
  logic [15:0] lpa_nxt;

  always_comb begin
    lpa_nxt = lpa_r;
    if (clear) begin
      lpa_nxt = ANR_LPA_RST;
    end
    if (word_valid) begin
      // flags and tech bits taken, reserved and T4 zero, selector fixed
      lpa_nxt = (word & ANR_LPA_KEEP_MASK) | {11'h000, ANR_SEL_8023};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lpa_r <= ANR_LPA_RST;
    end else begin
      lpa_r <= lpa_nxt;
    end
  end

  assign lpa = lpa_r;

  a_lpa_reserved: assert property (@(posedge clk) disable iff (!rstn)
    lpa_r[12:9] == 4'h0) else $error("partner reserved bits not zero");
  a_lpa_capture: assert property (@(posedge clk) disable iff (!rstn)
    word_valid |=> lpa_r[15:13] == $past(word[15:13])
      && lpa_r[8:5] == $past(word[8:5]))
    else $error("partner word not captured");
endmodule
`default_nettype wire

// >>> bench/anr_partner_model.sv
// Purpose: remote partner model sending one code word per request
// Assumes: requests come from the bench as one-cycle go pulses
// Notes: the word line toggles while idle so a stale word never looks valid
`timescale 1ns/10ps
`default_nettype none
module anr_partner_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic [15:0] go_word,
  input wire logic [3:0] gap,
  input wire logic tx_code_valid,
  output logic partner_word_valid,
  output logic [15:0] partner_word,
  output logic neg_complete
);
  // ==========================================
  // exchange: word after gap cycles, then done
  logic [3:0] cnt;
  logic [15:0] held;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      held <= 16'h0000;
      partner_word_valid <= 1'b0;
      partner_word <= 16'hFFFF;
      neg_complete <= 1'b0;
    end else begin
      partner_word_valid <= 1'b0;
      partner_word <= ~partner_word;
      neg_complete <= partner_word_valid;
      if (go) begin
        cnt <= gap;
        held <= go_word;
      end else if (cnt > 4'h1) begin
        cnt <= cnt - 4'h1;
      end else if (cnt == 4'h1 && tx_code_valid) begin
        // waits until the device is negotiating, as a real partner would
        cnt <= 4'h0;
        partner_word_valid <= 1'b1;
        partner_word <= held;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/test_autoneg_ability_registers.sv
// Purpose: self-checking bench for the ability register block
// Assumes: reads answered one cycle after the strobe, in order
// Notes: expected read data queued by the driver, compared by a monitor
`timescale 1ns/10ps
`default_nettype none
module test_autoneg_ability_registers import anr_pkg::*; ;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pin = 1'b0;
  anr_mgmt_req_s req = '0;
  logic fault = 1'b0;
  logic go = 1'b0;
  logic [15:0] go_word = 16'h0000;
  logic [3:0] gap = 4'h1;
  logic [15:0] rdata, pword, txw, w;
  logic rvalid, pvalid, pdone, txv;
  anr_mode_s mode;
  logic [15:0] expq[$];
  logic [15:0] words [5] = '{16'hFFFF, 16'h0000, 16'h8000, 16'h4000, 16'h2000};
  int err_total = 0;
  int checks_done = 0;
  always #4 clk = ~clk;

  anr_regs dut_u (.clk(clk), .rstn(rstn), .hardware_software_select_pin(pin),
    .mgmt_req(req), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .partner_word_valid(pvalid),
    .partner_word(pword), .neg_complete(pdone), .local_fault(fault), .tx_code_word(txw),
    .tx_code_valid(txv), .mode(mode));
  anr_partner_model peer_u (.clk(clk), .rstn(rstn), .go(go), .go_word(go_word), .gap(gap),
    .tx_code_valid(txv), .partner_word_valid(pvalid), .partner_word(pword),
    .neg_complete(pdone));

  // ==========================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    expq.push_back(e);
    @(posedge clk);
    req <= '0;
  endtask
  task automatic exchange(input logic [15:0] pw);
    @(posedge clk);
    go <= 1'b1;
    go_word <= pw;
    gap <= 4'($urandom_range(8, 1));
    @(posedge clk);
    go <= 1'b0;
    repeat (14) @(posedge clk);
    rd(ANR_LPA_ADDR, (pw & 16'hE1E0) | 16'h0001);
    rd(ANR_STAT_ADDR, 16'h7829);
    rd(ANR_QSTAT_ADDR, 16'h0010);
  endtask
  task automatic complete_run();
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================
  // read monitor: oldest note against each answer
  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) begin
        err_total++;
        $display("unexpected read data: expected none seen %h", rdata);
      end else begin
        check("read data", rdata, expq.pop_front());
      end
    end
  end

  // ==========================================
  // main sequence and watchdog
  initial begin
    w = $urandom(32'h577B);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(ANR_ADV_ADDR, 16'h01E1);
    rd(ANR_LPA_ADDR, 16'h0000);
    rd(ANR_STAT_ADDR, 16'h7809);
    rd(5'h1F, 16'h0000);
    check("code word", txw, 16'h01E1);
    wr(ANR_EXT_ADDR, 16'h8000);
    rd(ANR_EXT_ADDR, 16'h8000);
    wr(ANR_ADV_ADDR, 16'h0001);
    rd(ANR_ADV_ADDR, 16'h01E1);
    pin <= 1'b1;
    wr(ANR_EXT_ADDR, 16'h0000);
    wr(ANR_ADV_ADDR, 16'h0001);
    rd(ANR_ADV_ADDR, 16'h01E1);
    wr(ANR_EXT_ADDR, 16'h8000);
    for (int i = 0; i < 6; i++) begin
      w = (16'($urandom()) & 16'h01E0) | 16'h0001;
      wr(ANR_ADV_ADDR, w);
      rd(ANR_ADV_ADDR, w);
      wr(ANR_CTRL_ADDR, 16'h3300);
      @(posedge clk);
      #1;
      check("code valid", {15'h0000, txv}, 16'h0001);
      check("code word", txw, w);
      check("mode", {12'h000, mode}, 16'h000E);
      rd(ANR_LPA_ADDR, 16'h0000);
      exchange(i < 5 ? words[i] : 16'($urandom()));
    end
    fault <= 1'b1;
    rd(ANR_ADV_ADDR, w | 16'h2000);
    for (int i = 0; i < 4; i++) begin
      wr(ANR_CTRL_ADDR, {2'b00, i[1], 4'h0, i[0], 8'h00});
      rd(ANR_CTRL_ADDR, {2'b00, i[1], 4'h0, i[0], 8'h00});
      repeat (3) @(posedge clk);
      #1;
      check("mode", {12'h000, mode}, {12'h000, i[1], i[0], 2'b01});
      check("code valid", {15'h0000, txv}, 16'h0000);
    end
    repeat (4) @(posedge clk);
    check("pending reads", 16'(expq.size()), 16'h0000);
    complete_run();
  end
  initial begin
    // far beyond the few hundred cycles the sequence needs
    #100000;
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
